// ==== logic/test_port_pkg.sv ====
// Register map, field layout, reset values and carriers of the test page.
// Assumes an 8-bit register port with a 6-bit address on one clock.
package test_port_pkg;

   // Register addresses
   localparam logic [5:0] ADDR_TIMER_LO  = 6'h2f;
   localparam logic [5:0] ADDR_RSVD      = 6'h30;
   localparam logic [5:0] ADDR_LINE_SEL  = 6'h31;
   localparam logic [5:0] ADDR_GROUP_CTL = 6'h32;
   localparam logic [5:0] ADDR_DRV_EN    = 6'h33;
   localparam logic [5:0] ADDR_PIN_LVL   = 6'h34;
   localparam logic [5:0] ADDR_BUS_STAT  = 6'h35;

   // Values after reset
   localparam logic [7:0] RST_RSVD      = 8'h00;
   localparam logic [7:0] RST_LINE_SEL  = 8'h00;
   localparam logic [7:0] RST_GROUP_CTL = 8'h00;
   localparam logic [7:0] RST_DRV_EN    = 8'h80;
   localparam logic [7:0] RST_PIN_LVL   = 8'h00;

   // Field positions
   localparam int LINE_SEL_MSB = 2;
   localparam int GROUP_MSB    = 4;
   localparam int BIT_FLIP     = 7;
   localparam int BIT_PRBS9    = 6;
   localparam int BIT_PRBS15   = 5;
   localparam int BIT_UART_EN  = 7;
   localparam int BIT_IO_SEL   = 7;
   localparam int PORT_LSB     = 1;
   localparam int PORT_MSB     = 6;

   // Second analog selector code that also routes the line to the aux pins
   localparam logic [3:0] SECOND_ANALOG_TEST_PIN_ALL_ONES = 4'hf;
   // Pins D1 to D4 only, when a serial link claims D5 and D6
   localparam logic [5:0] LIMIT_MASK = 6'h0f;

   // Pattern generator lengths and seed
   localparam int PRBS9_LEN  = 9;
   localparam int PRBS15_LEN = 15;
   localparam logic [14:0] PRBS_SEED = 15'h7fff;

   // Register port request and answer
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } reg_rsp_t;

   // Which host interface is active
   typedef struct packed {
      logic spi;
      logic uart;
      logic serial;
   } host_if_t;

   // Drive of data pins D6..D1
   typedef struct packed {
      logic [5:0] out;
      logic [5:0] oe;
   } port_drive_t;

   typedef enum logic [1:0] {
      PRBS_IDLE  = 2'b00,
      PRBS_ARMED = 2'b01,
      PRBS_SEND  = 2'b11
   } prbs_state_t;

endpackage

// ==== logic/test_bus_router.sv ====
// Test bus group, line and parallel port selection.
// Assumes the groups arrive as 32 bytes from the internal sources.
`timescale 1ns/1ps
module test_bus_router (
   input  wire logic [31:0][7:0] groups,
   input  wire logic [4:0]       groupSel,
   input  wire logic [2:0]       lineSel,
   input  wire logic             flip,
   output logic      [7:0]       busByte,
   output logic                  busLine,
   output logic      [5:0]       portMap
);

   // Group, then single line of it
   assign busByte = groups[groupSel];
   assign busLine = busByte[lineSel];

   // Pin D6..D1 order, plain or reordered
   assign portMap = flip ? {busByte[4], busByte[3], busByte[2],
                            busByte[6], busByte[5], busByte[0]}
                         : busByte[5:0];

endmodule

// ==== logic/prbs_source.sv ====
// Pseudo-random pattern source, armed by enable bits, run by transmit.
// Assumes transmitCmd is a one-cycle pulse from the command logic.
`timescale 1ns/1ps
module prbs_source (
   input  wire logic mclk,
   input  wire logic rst_n,
   input  wire logic enPrbs9,
   input  wire logic enPrbs15,
   input  wire logic transmitCmd,
   output logic      prbsBit,
   output logic      prbsActive
);

   test_port_pkg::prbs_state_t state_r;
   test_port_pkg::prbs_state_t state_nxt;
   logic [14:0] lfsr_r;
   logic        mode15_r;
   logic        anyEn;
   logic        fb;

   // Nine-bit pattern wins when both are set
   assign anyEn = enPrbs9 | enPrbs15;
   assign fb = mode15_r ? (lfsr_r[14] ^ lfsr_r[13])
                        : (lfsr_r[8] ^ lfsr_r[4]);

   // Armed on enable, sending only after transmit
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         test_port_pkg::PRBS_IDLE:
            if (anyEn) state_nxt = test_port_pkg::PRBS_ARMED;
         test_port_pkg::PRBS_ARMED:
            if (!anyEn) state_nxt = test_port_pkg::PRBS_IDLE;
            else if (transmitCmd) state_nxt = test_port_pkg::PRBS_SEND;
         test_port_pkg::PRBS_SEND:
            if (!anyEn) state_nxt = test_port_pkg::PRBS_IDLE;
         default: state_nxt = test_port_pkg::PRBS_IDLE;
      endcase
   end

   // State, mode capture and shift register
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_r  <= test_port_pkg::PRBS_IDLE;
         lfsr_r   <= test_port_pkg::PRBS_SEED;
         mode15_r <= 1'b0;
      end else begin
         state_r <= state_nxt;
         if (state_r != test_port_pkg::PRBS_SEND) begin
            lfsr_r   <= test_port_pkg::PRBS_SEED;
            mode15_r <= enPrbs15 & ~enPrbs9;
         end else begin
            lfsr_r <= {lfsr_r[13:0], fb};
         end
      end
   end

   assign prbsActive = (state_r == test_port_pkg::PRBS_SEND);
   assign prbsBit    = prbsActive & (mode15_r ? lfsr_r[14] : lfsr_r[8]);

   a_prbs_hold:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == test_port_pkg::PRBS_ARMED) && !transmitCmd
      |=> !prbsActive)
   else $error("pattern sent without transmit command");

   a_prbs_start:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (state_r == test_port_pkg::PRBS_ARMED) && transmitCmd && anyEn
      |=> prbsActive)
   else $error("transmit command did not start pattern");

endmodule

// ==== logic/test_port_regs.sv ====
// Test page registers: test bus routing, pattern control and data port.
// Assumes the register port request is a single-cycle strobe and that
// the host interface mode and the timer count come from the core.
//
// Functional notes
// - Timer low byte read-only at 2Fh, live count, no reset value.
// - Register 30h has no function and reads zero.
// - Three-bit line selector picks test bus line for test output pin.
// - Second analog selector all ones also drives line onto aux pins.
// - Reorder bit maps bus bits 4,3,2,6,5,0 onto the port.
// - Nine-bit pattern enable arms source; transmit command starts it.
// - Fifteen-bit pattern enable arms source; transmit command starts it.
// - Five-bit group selector picks test bus group for outputs and view.
// - Clearing the UART line enable gates both sideband lines; reset one.
// - Each driver enable bit one to six enables data pin of same number.
// - With SPI, or UART with lines on, only pins D1 to D4 usable.
// - Port I/O bit with serial host makes port general I/O.
// - Port level field sets pin level only where driver enabled.
// - Level register reads live pins when port I/O bit set, any host, else stored value.
// - Status byte shows eight lines of selected test bus group.
`timescale 1ns/1ps
module test_port_regs (
   input  wire logic                    mclk,
   input  wire logic                    rst_n,
   input  wire test_port_pkg::reg_req_t regReq,
   output test_port_pkg::reg_rsp_t      regRsp,
   input  wire logic [15:0]             timerCount,
   input  wire logic [7:0]              analogPinSel,
   input  wire logic [31:0][7:0]        testBusGroups,
   input  wire test_port_pkg::host_if_t hostIf,
   input  wire logic                    transmitCmd,
   input  wire logic [5:0]              dataPinIn,
   output test_port_pkg::port_drive_t   dataPin,
   output logic                         testOutPin,
   output logic                         firstAuxOut,
   output logic                         secondAuxOut,
   output logic                         auxOe,
   output logic                         uartLineAEn,
   output logic                         uartLineBEn,
   output logic                         prbsBit,
   output logic                         prbsActive
);

   // Stored fields
   logic [2:0] lineSel_r;
   logic [7:0] groupCtl_r;
   logic       uartEn_r;
   logic [5:0] drvEn_r;
   logic       ioSel_r;
   logic [5:0] pinLvl_r;
   logic [7:0] rdData_r;
   logic       rdValid_r;
   logic       testOut_r;
   logic       auxOe_r;
   logic [5:0] pinOut_r;
   logic [5:0] pinOe_r;

   // Decoded controls
   logic [7:0] busByte;
   logic       busLine;
   logic [5:0] portMap;
   logic       gpioMode;
   logic       restricted;
   logic [5:0] usableMask;
   logic [5:0] pinOut_nxt;
   logic [5:0] pinOe_nxt;
   logic [7:0] rdData_nxt;
   logic       wrLineSel;
   logic       wrGroupCtl;
   logic       wrDrvEn;
   logic       wrPinLvl;
   logic [7:0] lvlView;

   // Address match for a strobe
   function automatic logic hit(input test_port_pkg::reg_req_t r,
                                input logic [5:0] a);
      hit = (r.addr == a);
   endfunction

   // Write decode
   assign wrLineSel  = regReq.wr & hit(regReq, test_port_pkg::ADDR_LINE_SEL);
   assign wrGroupCtl = regReq.wr & hit(regReq, test_port_pkg::ADDR_GROUP_CTL);
   assign wrDrvEn    = regReq.wr & hit(regReq, test_port_pkg::ADDR_DRV_EN);
   assign wrPinLvl   = regReq.wr & hit(regReq, test_port_pkg::ADDR_PIN_LVL);

   // Register writes; reserved bits are never stored
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         lineSel_r  <= test_port_pkg::RST_LINE_SEL[2:0];
         groupCtl_r <= test_port_pkg::RST_GROUP_CTL;
         uartEn_r   <= test_port_pkg::RST_DRV_EN[7];
         drvEn_r    <= test_port_pkg::RST_DRV_EN[6:1];
         ioSel_r    <= test_port_pkg::RST_PIN_LVL[7];
         pinLvl_r   <= test_port_pkg::RST_PIN_LVL[6:1];
      end else begin
         if (wrLineSel)
            lineSel_r <= regReq.wdata[test_port_pkg::LINE_SEL_MSB:0];
         if (wrGroupCtl)
            groupCtl_r <= regReq.wdata;
         if (wrDrvEn) begin
            uartEn_r <= regReq.wdata[test_port_pkg::BIT_UART_EN];
            drvEn_r  <= regReq.wdata[test_port_pkg::PORT_MSB:
                                     test_port_pkg::PORT_LSB];
         end
         if (wrPinLvl) begin
            ioSel_r  <= regReq.wdata[test_port_pkg::BIT_IO_SEL];
            pinLvl_r <= regReq.wdata[test_port_pkg::PORT_MSB:
                                     test_port_pkg::PORT_LSB];
         end
      end
   end

   // Group, line and port order selection
   test_bus_router u_router (
      .groups   (testBusGroups),
      .groupSel (groupCtl_r[test_port_pkg::GROUP_MSB:0]),
      .lineSel  (lineSel_r),
      .flip     (groupCtl_r[test_port_pkg::BIT_FLIP]),
      .busByte  (busByte),
      .busLine  (busLine),
      .portMap  (portMap)
   );

   // Pattern generator, armed by the two enable bits
   prbs_source u_prbs (
      .mclk        (mclk),
      .rst_n       (rst_n),
      .enPrbs9     (groupCtl_r[test_port_pkg::BIT_PRBS9]),
      .enPrbs15    (groupCtl_r[test_port_pkg::BIT_PRBS15]),
      .transmitCmd (transmitCmd),
      .prbsBit     (prbsBit),
      .prbsActive  (prbsActive)
   );

   // Port mode and usable pins
   assign gpioMode   = ioSel_r & hostIf.serial;
   assign restricted = hostIf.spi | (hostIf.uart & uartEn_r);
   assign usableMask = restricted ? test_port_pkg::LIMIT_MASK : 6'h3f;
   assign pinOe_nxt  = drvEn_r & usableMask;
   assign pinOut_nxt = gpioMode ? (pinLvl_r & drvEn_r)
                                : (portMap & drvEn_r);

   // Level register view: live pins when the port I/O bit is set, any host
   assign lvlView = ioSel_r ? {1'b1, dataPinIn, 1'b0}
                            : {1'b0, pinLvl_r, 1'b0};

   // Read data selection; unmapped addresses read zero
   always_comb begin
      rdData_nxt = 8'h00;
      case (regReq.addr)
         test_port_pkg::ADDR_TIMER_LO:  rdData_nxt = timerCount[7:0];
         test_port_pkg::ADDR_RSVD:
            rdData_nxt = test_port_pkg::RST_RSVD;
         test_port_pkg::ADDR_LINE_SEL:  rdData_nxt = {5'h00, lineSel_r};
         test_port_pkg::ADDR_GROUP_CTL: rdData_nxt = groupCtl_r;
         test_port_pkg::ADDR_DRV_EN:    rdData_nxt = {uartEn_r, drvEn_r, 1'b0};
         test_port_pkg::ADDR_PIN_LVL:   rdData_nxt = lvlView;
         test_port_pkg::ADDR_BUS_STAT:  rdData_nxt = busByte;
         default:                       rdData_nxt = 8'h00;
      endcase
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rdData_r  <= 8'h00;
         rdValid_r <= 1'b0;
      end else begin
         rdValid_r <= regReq.rd;
         if (regReq.rd)
            rdData_r <= rdData_nxt;
      end
   end

   // Registered pin and test outputs
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         testOut_r <= 1'b0;
         auxOe_r   <= 1'b0;
         pinOut_r  <= 6'h00;
         pinOe_r   <= 6'h00;
      end else begin
         testOut_r <= busLine;
         auxOe_r   <= (analogPinSel[3:0] ==
                       test_port_pkg::SECOND_ANALOG_TEST_PIN_ALL_ONES);
         pinOut_r  <= pinOut_nxt;
         pinOe_r   <= pinOe_nxt;
      end
   end

   // Output assignments
   assign regRsp       = '{valid: rdValid_r, data: rdData_r};
   assign dataPin      = '{out: pinOut_r, oe: pinOe_r};
   assign testOutPin   = testOut_r;
   assign firstAuxOut  = testOut_r & auxOe_r;
   assign secondAuxOut = testOut_r & auxOe_r;
   assign auxOe        = auxOe_r;
   assign uartLineAEn  = uartEn_r;
   assign uartLineBEn  = uartEn_r;

   a_timer_read:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_TIMER_LO)
      |=> regRsp.valid && (regRsp.data == $past(timerCount[7:0])))
   else $error("timer low byte read wrong");

   a_reserved_zero:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_RSVD)
      |=> (regRsp.data == 8'h00))
   else $error("reserved register read nonzero");

   a_line_route:
   assert property (@(posedge mclk) disable iff (!rst_n)
      $stable(lineSel_r) && $stable(groupCtl_r)
      |=> testOutPin == $past(testBusGroups[groupCtl_r[4:0]][lineSel_r]))
   else $error("test output pin carries wrong line");

   a_aux_drive:
   assert property (@(posedge mclk) disable iff (!rst_n)
      ##1 auxOe == ($past(analogPinSel[3:0]) == 4'hf))
   else $error("aux pin drive does not follow selector");

   a_flip_order:
   assert property (@(posedge mclk) disable iff (!rst_n)
      groupCtl_r[7] && !gpioMode && (drvEn_r == 6'h3f)
      |=> dataPin.out == $past({busByte[4], busByte[3], busByte[2],
                                busByte[6], busByte[5], busByte[0]}))
   else $error("reordered port mapping wrong");

   a_status_view:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_BUS_STAT)
      |=> regRsp.data == $past(testBusGroups[groupCtl_r[4:0]]))
   else $error("status view is not the selected group");

   a_uart_gate:
   assert property (@(posedge mclk) disable iff (!rst_n)
      wrDrvEn && !regReq.wdata[7] |=> !uartLineAEn && !uartLineBEn)
   else $error("sideband lines not gated");

   a_limit_pins:
   assert property (@(posedge mclk) disable iff (!rst_n)
      (hostIf.spi || (hostIf.uart && uartEn_r)) |=> $past(restricted)
      && (dataPin.oe[5:4] == 2'b00))
   else $error("pins D5 or D6 driven while restricted");

   a_gpio_levels:
   assert property (@(posedge mclk) disable iff (!rst_n)
      gpioMode |=> dataPin.out == ($past(pinLvl_r) & $past(drvEn_r)))
   else $error("port level not driven in I/O mode");

   a_live_readback:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_PIN_LVL) && ioSel_r
      |=> regRsp.data[6:1] == $past(dataPinIn))
   else $error("level register not showing live pins");

   a_rsvd_bits:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_DRV_EN
                    || regReq.addr == test_port_pkg::ADDR_PIN_LVL)
      |=> (regRsp.data[0] == 1'b0))
   else $error("reserved bit reads nonzero");

   a_line_upper:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_LINE_SEL)
      |=> (regRsp.data[7:3] == 5'h00))
   else $error("reserved selector bits read nonzero");

   a_stored_readback:
   assert property (@(posedge mclk) disable iff (!rst_n)
      regReq.rd && (regReq.addr == test_port_pkg::ADDR_PIN_LVL) && !ioSel_r
      |=> regRsp.data == {1'b0, $past(pinLvl_r), 1'b0})
   else $error("level register not showing stored value");

   a_drv_enable:
   assert property (@(posedge mclk) disable iff (!rst_n)
      !restricted |=> dataPin.oe == $past(drvEn_r))
   else $error("driver enables not on their own pins");

   a_serial_only:
   assert property (@(posedge mclk) disable iff (!rst_n)
      ioSel_r && !hostIf.serial |=> dataPin.out == $past(portMap & drvEn_r))
   else $error("port run as I/O without a serial host");

   a_sideband_on:
   assert property (@(posedge mclk) disable iff (!rst_n)
      wrDrvEn && regReq.wdata[7] |=> uartLineAEn && uartLineBEn)
   else $error("sideband lines not enabled");

   a_group_write:
   assert property (@(posedge mclk) disable iff (!rst_n)
      wrGroupCtl |=> groupCtl_r == $past(regReq.wdata))
   else $error("group selector write lost");

   a_reset_state:
   assert property (@(posedge mclk) disable iff (!rst_n)
      $past(!rst_n) |-> uartEn_r && (drvEn_r == 6'h00) && !ioSel_r
      && (groupCtl_r == 8'h00) && (lineSel_r == 3'h0))
   else $error("test fields not at reset values");

endmodule

// ==== verification/host_model.sv ====
// Host side of the register port: single-strobe writes and reads.
// Assumes the device takes a strobe at a rising edge and answers a
// read one edge later.
`timescale 1ns/1ps
module host_model (
   input  wire logic                    mclk,
   input  wire test_port_pkg::reg_rsp_t regRsp,
   output test_port_pkg::reg_req_t      regReq
);
   initial regReq = '0;

   // Write strobe, released with scrambled address and data
   task automatic writeReg(input logic [5:0] a, input logic [7:0] d);
      @(posedge mclk);
      regReq <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge mclk);
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
   endtask

   // Read strobe; answer taken once it has settled
   task automatic readReg(input logic [5:0] a, output logic [7:0] d,
                          output logic v);
      @(posedge mclk);
      regReq <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h5a};
      @(posedge mclk);
      regReq <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'ha5};
      #1;
      v = regRsp.valid;
      d = regRsp.data;
   endtask
endmodule

// ==== verification/test_port_regs_bench.sv ====
// Self-checking bench for the test page register block.
// Assumes host_model drives the register port; the bench drives the
// core inputs and resolves the data pins from both drivers.
`timescale 1ns/1ps
`define CHECK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
   failures++; $display("MISMATCH t=%0t got %h exp %h", $time, got, exp); \
   end end
module test_port_regs_bench;
   localparam int LIMIT = 40000;
   logic                       mclk;
   logic                       rst_n;
   logic                       transmitCmd;
   test_port_pkg::reg_req_t    regReq;
   test_port_pkg::reg_rsp_t    regRsp;
   test_port_pkg::host_if_t    hostIf;
   test_port_pkg::port_drive_t dataPin;
   logic [15:0]                timerCount;
   logic [7:0]                 analogPinSel;
   logic [31:0][7:0]           groups;
   logic [5:0]                 dataPinIn;
   logic [5:0]                 extLevel;
   logic                       testOutPin;
   logic                       firstAuxOut;
   logic                       secondAuxOut;
   logic                       auxOe;
   logic                       uartLineAEn;
   logic                       uartLineBEn;
   logic                       prbsBit;
   logic                       prbsActive;
   logic [7:0]                 g3;
   int                         failures = 0;
   int                         num_checks = 0;
   int                         cycles = 0;

   // Pin level: device driver where enabled, outside level elsewhere
   assign dataPinIn = (dataPin.oe & dataPin.out) | (~dataPin.oe & extLevel);
   assign g3 = groups[3];

   test_port_regs uut (
      .mclk(mclk), .rst_n(rst_n), .regReq(regReq), .regRsp(regRsp),
      .timerCount(timerCount), .analogPinSel(analogPinSel),
      .testBusGroups(groups), .hostIf(hostIf),
      .transmitCmd(transmitCmd), .dataPinIn(dataPinIn),
      .dataPin(dataPin), .testOutPin(testOutPin),
      .firstAuxOut(firstAuxOut), .secondAuxOut(secondAuxOut),
      .auxOe(auxOe), .uartLineAEn(uartLineAEn),
      .uartLineBEn(uartLineBEn), .prbsBit(prbsBit),
      .prbsActive(prbsActive)
   );

   host_model host (
      .mclk(mclk), .regRsp(regRsp), .regReq(regReq)
   );

   // Clock and cycle ceiling
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cycles++;
      if (cycles == LIMIT) begin
         failures++;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Let one edge land and step off it
   task automatic settle();
      @(posedge mclk);
      #1;
   endtask

   task automatic chkReg(input logic [5:0] a, input logic [7:0] e);
      logic [7:0] d;
      logic       v;
      host.readReg(a, d, v);
      `CHECK(v, 1'b1)
      `CHECK(d, e)
   endtask

   task automatic tReset();
      chkReg(6'h30, 8'h00);
      chkReg(6'h31, 8'h00);
      chkReg(6'h32, 8'h00);
      chkReg(6'h33, 8'h80);
      chkReg(6'h34, 8'h00);
      `CHECK({uartLineAEn, uartLineBEn}, 2'b11)
      `CHECK({dataPin, auxOe, prbsActive}, 14'h0000)
      $display("test reset done");
   endtask

   // Timer byte is live and read-only; reserved places drop writes
   task automatic tReadOnly();
      @(posedge mclk) timerCount <= 16'ha55a;
      chkReg(6'h2f, 8'h5a);
      host.writeReg(6'h2f, 8'h00);
      @(posedge mclk) timerCount <= 16'h12c3;
      chkReg(6'h2f, 8'hc3);
      host.writeReg(6'h30, 8'hff);
      chkReg(6'h30, 8'h00);
      host.writeReg(6'h31, 8'hff);
      chkReg(6'h31, 8'h07);
      host.writeReg(6'h33, 8'h01);
      chkReg(6'h33, 8'h00);
      host.writeReg(6'h34, 8'h01);
      chkReg(6'h34, 8'h00);
      chkReg(6'h3f, 8'h00);
      $display("test read-only done");
   endtask

   // Group and line selection, status view and aux routing
   task automatic tRoute();
      int gs[3] = '{0, 7, 31};
      foreach (gs[k]) begin
         host.writeReg(6'h32, 8'(gs[k]));
         for (int l = 0; l < 8; l++) begin
            host.writeReg(6'h31, 8'(l));
            settle();
            `CHECK(testOutPin, groups[gs[k]][l])
         end
         chkReg(6'h35, groups[gs[k]]);
      end
      @(posedge mclk) analogPinSel <= 8'h0f;
      settle();
      settle();
      `CHECK(auxOe, 1'b1)
      `CHECK({firstAuxOut, secondAuxOut}, {2{groups[31][7]}})
      @(posedge mclk) analogPinSel <= 8'hf0;
      settle();
      settle();
      `CHECK({auxOe, firstAuxOut, secondAuxOut}, 3'b000)
      $display("test route done");
   endtask

   // Parallel port drivers, reorder and serial-link restriction
   task automatic tPort();
      host.writeReg(6'h33, 8'h7e);
      host.writeReg(6'h32, 8'h03);
      settle();
      `CHECK(dataPin, {g3[5:0], 6'h3f})
      `CHECK({uartLineAEn, uartLineBEn}, 2'b00)
      host.writeReg(6'h32, 8'h83);
      settle();
      `CHECK(dataPin.out, {g3[4], g3[3], g3[2], g3[6], g3[5], g3[0]})
      host.writeReg(6'h33, 8'h12);
      settle();
      `CHECK(dataPin.oe, 6'h09)
      @(posedge mclk) hostIf <= '{spi: 1'b1, uart: 1'b0, serial: 1'b1};
      host.writeReg(6'h33, 8'h7e);
      settle();
      `CHECK(dataPin.oe, 6'h0f)
      @(posedge mclk) hostIf <= '{spi: 1'b0, uart: 1'b1, serial: 1'b1};
      settle();
      settle();
      `CHECK(dataPin.oe, 6'h3f)
      host.writeReg(6'h33, 8'hfe);
      settle();
      `CHECK(dataPin.oe, 6'h0f)
      `CHECK({uartLineAEn, uartLineBEn}, 2'b11)
      $display("test port done");
   endtask

   // General I/O with a serial host: levels, masking and readback
   task automatic tGpio();
      @(posedge mclk) extLevel <= 6'h0a;
      host.writeReg(6'h33, 8'h2a);
      host.writeReg(6'h34, 8'hfe);
      settle();
      `CHECK(dataPin, 12'h555)
      chkReg(6'h34, 8'hbe);
      @(posedge mclk) hostIf <= '0;
      settle();
      `CHECK(dataPin.out, 6'h15 & {g3[4:2], g3[6:5], g3[0]})
      host.writeReg(6'h34, 8'h4c);
      settle();
      `CHECK(dataPin.out, 6'h15 & {g3[4:2], g3[6:5], g3[0]})
      chkReg(6'h34, 8'h4c);
      $display("test gpio done");
   endtask

   task automatic pulseTx();
      @(posedge mclk) transmitCmd <= 1'b1;
      @(posedge mclk) transmitCmd <= 1'b0;
      settle();
   endtask

   // Count ones and active cycles over a window of the pattern
   task automatic runPattern(input int n, input int ones);
      int cnt;
      int act;
      cnt = 0;
      act = 0;
      repeat (n) begin
         settle();
         if (prbsBit === 1'b1) cnt++;
         if (prbsActive === 1'b1) act++;
      end
      `CHECK(cnt, ones)
      `CHECK(act, n)
   endtask

   // Armed patterns wait for transmit, then run one full period
   task automatic tPrbs();
      host.writeReg(6'h32, 8'h03);
      host.writeReg(6'h32, 8'h43);
      settle();
      `CHECK({prbsActive, prbsBit}, 2'b00)
      pulseTx();
      `CHECK(prbsActive, 1'b1)
      runPattern(511, 256);
      host.writeReg(6'h32, 8'h03);
      settle();
      `CHECK({prbsActive, prbsBit}, 2'b00)
      host.writeReg(6'h32, 8'h23);
      settle();
      `CHECK(prbsActive, 1'b0)
      pulseTx();
      runPattern(32767, 16384);
      $display("test pattern done");
   endtask

   initial begin
      rst_n = 1'b0;
      transmitCmd = 1'b0;
      hostIf = '0;
      timerCount = '0;
      analogPinSel = '0;
      extLevel = '0;
      for (int i = 0; i < 32; i++) groups[i] = 8'(i * 8'h25 + 8'h5b);
      repeat (8) @(posedge mclk);
      rst_n <= 1'b1;
      tReset();
      tReadOnly();
      tRoute();
      tPort();
      tGpio();
      tPrbs();
      print_verdict();
   end
endmodule
